/* mcr_pkg.sv */
/*
  Constants, field layouts and carrier types for the margin and protection
  configuration register bank.
  Assumes a single 40 MHz system clock and a two-wire serial bus slave.
*/
package mcr_pkg;

  // Register address bytes
  localparam logic [7:0] MCR_ADR_MARGIN  = 8'h00;
  localparam logic [7:0] MCR_ADR_PROTCFG = 8'h01;

  // Slave address: upper six bits fixed, lowest bit from the strap
  localparam logic [5:0] MCR_DEV_ADDR_HI = 6'h23;

  // Reset values of both registers
  localparam logic [7:0] MCR_MARGIN_RST  = 8'h00;
  localparam logic [7:0] MCR_PROTCFG_RST = 8'h00;

  // Field positions
  localparam int MCR_OFFSET_LSB   = 0;
  localparam int MCR_FREQ_LSB     = 0;
  localparam int MCR_OVP_BIT      = 3;
  localparam int MCR_DEADTIME_LSB = 4;

  // Margin step, in microvolts
  localparam int MCR_OFFSET_STEP_UV = 12500;

  // Byte and burst counts
  localparam logic [3:0] MCR_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] MCR_BURST_FROM_0  = 2'h2;
  localparam logic [1:0] MCR_BURST_SINGLE  = 2'h1;

  // Cycles after reset release before the address strap is sampled
  localparam logic [1:0] MCR_STRAP_DELAY = 2'h3;

  // Switching frequency shift codes
  typedef enum logic [2:0] {
    MCR_FREQ_NOMINAL = 3'h0,
    MCR_FREQ_MINUS15 = 3'h1,
    MCR_FREQ_MINUS30 = 3'h2,
    MCR_FREQ_PLUS15  = 3'h3,
    MCR_FREQ_PLUS30  = 3'h4
  } mcr_freq_t;

  // Adaptive dead-time detection schemes
  typedef enum logic [1:0] {
    MCR_DT_PHASE_NODE = 2'h0,
    MCR_DT_LOW_GATE   = 2'h1
  } mcr_deadtime_t;

  typedef struct packed {
    logic [1:0] ignored;
    logic [5:0] offset_code;
  } mcr_margin_t;

  typedef struct packed {
    logic [1:0] ignored;
    logic [1:0] deadtime_sel;
    logic       overvoltage_level_sel;
    logic [2:0] freq_sel;
  } mcr_protcfg_t;

  typedef struct packed {
    mcr_margin_t  margin_register;
    mcr_protcfg_t protection_config_register;
  } mcr_cfg_t;

  // Bus engine states
  typedef enum logic [3:0] {
    MCR_ST_IDLE    = 4'h0,
    MCR_ST_DEV     = 4'h1,
    MCR_ST_DEV_ACK = 4'h2,
    MCR_ST_REGADR  = 4'h3,
    MCR_ST_REG_ACK = 4'h4,
    MCR_ST_WR      = 4'h5,
    MCR_ST_WR_ACK  = 4'h6,
    MCR_ST_RD      = 4'h7,
    MCR_ST_RD_ACK  = 4'h8
  } mcr_state_t;

endpackage

/* mcr_sync.sv */
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes inputs are quasi-static levels; no pulse narrower than a clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mcr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

/* mcr_regs.sv */
/*
  Margin and protection configuration register bank with its two-wire
  serial slave. Writes are staged and applied at the stop condition.
  Assumes rst_n is the power-on reset, asserted below the falling supply
  threshold; scl, sda, the reset-pin comparator and the strap are async.
*/
// Behaviour
// [R01] Both registers zero after power-up
// [R02] Bus writes accepted any time after power-up
// [R03] Supply below falling threshold clears both registers
// [R04] Reset pin low clears both registers
// [R05] Clears never stop regulation nor restart soft-start
// [R06] Margin code bits 5:0, 12.5 mV steps
// [R07] Dead-time 5:4, overvoltage bit 3, frequency 2:0
// [R08] Frequency codes nominal, -15, -30, +15, +30
// [R09] Overvoltage bit: default clear, alternate set
// [R10] Dead-time 00 phase node, 01 low gate
// [R11] Master shifts frequency in 15% steps
// [R12] Register address 00 margin, 01 protection config
// [R13] Second byte after address 00 goes to 01
// [R14] Master sets address then stops before reading
// [R15] New values applied at write stop
// [R16] Reset pin synchronised before clearing registers
`timescale 1ns/1ps
`default_nettype none

module mcr_regs (
  // Clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Serial bus, open drain data
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Soft-start/reset/address pin
  input  wire logic              ss_pin_below_thr,
  input  wire logic              ss_pin_strap_high,
  // Configuration to the regulator
  output mcr_pkg::mcr_cfg_t      cfg
);

  logic [3:0] sync_o;
  logic       scl_s;
  logic       sda_s;
  logic       pin_low_s;
  logic       strap_s;

  mcr_sync #(.W(4)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({scl_in, sda_in, ss_pin_below_thr, ss_pin_strap_high}),
    .sync_out (sync_o)
  );

  assign {scl_s, sda_s, pin_low_s, strap_s} = sync_o;

  mcr_pkg::mcr_state_t st_q,    st_d;
  mcr_pkg::mcr_cfg_t   cfg_q,   cfg_d;
  logic [7:0]          sh_q,    sh_d;
  logic [7:0]          stg0_q,  stg0_d;
  logic [7:0]          stg1_q,  stg1_d;
  logic [3:0]          cnt_q,   cnt_d;
  logic [1:0]          nwr_q,   nwr_d;
  logic [1:0]          lim_q,   lim_d;
  logic [1:0]          dly_q,   dly_d;
  logic                ptr_q,   ptr_d;
  logic                rw_q,    rw_d;
  logic                mack_q,  mack_d;
  logic                wr0_q,   wr0_d;
  logic                wr1_q,   wr1_d;
  logic                oe_q,    oe_d;
  logic                a0_q,    a0_d;
  logic                cap_q,   cap_d;
  logic                scl_p_q, sda_p_q;
  logic                scl_rise, scl_fall, start_c, stop_c;
  logic [7:0]          rd_cur,  rd_last;

  // Read-back of the register a pointer selects
  function automatic logic [7:0] rd_byte(input logic p, input mcr_pkg::mcr_cfg_t c);
    rd_byte = p ? c.protection_config_register : c.margin_register;
  endfunction

  // Bytes offered to a reader: at the pointer, and the parked last register
  assign rd_cur  = rd_byte(ptr_q, cfg_q);
  assign rd_last = rd_byte(1'b1, cfg_q);

  // Bus line events; held off until the sync reset zeros have flushed
  always_comb begin
    scl_rise = cap_q & scl_s & ~scl_p_q;
    scl_fall = cap_q & ~scl_s & scl_p_q;
    start_c  = cap_q & scl_s & scl_p_q & sda_p_q & ~sda_s;
    stop_c   = cap_q & scl_s & scl_p_q & ~sda_p_q & sda_s;
  end

  // Next-state logic of the bus engine and the register bank
  always_comb begin
    st_d   = st_q;
    cfg_d  = cfg_q;
    sh_d   = sh_q;
    stg0_d = stg0_q;
    stg1_d = stg1_q;
    cnt_d  = cnt_q;
    nwr_d  = nwr_q;
    lim_d  = lim_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    mack_d = mack_q;
    wr0_d  = wr0_q;
    wr1_d  = wr1_q;
    oe_d   = oe_q;
    // Strap caught once, a few cycles after release so the sync has settled
    dly_d  = (dly_q == mcr_pkg::MCR_STRAP_DELAY) ? dly_q : dly_q + 2'h1;
    cap_d  = cap_q | (dly_q == mcr_pkg::MCR_STRAP_DELAY);
    a0_d   = (!cap_q && dly_q == mcr_pkg::MCR_STRAP_DELAY) ? strap_s : a0_q;
    if (start_c) begin
      st_d  = mcr_pkg::MCR_ST_DEV;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_c) begin
      st_d = mcr_pkg::MCR_ST_IDLE;
      oe_d = 1'b0;
      // Staged bytes reach the regulator only now
      if (wr0_q) cfg_d.margin_register = stg0_q; // [R15]
      if (wr1_q) cfg_d.protection_config_register = stg1_q; // [R15]
      wr0_d = 1'b0;
      wr1_d = 1'b0;
    end else begin
      case (st_q)
        mcr_pkg::MCR_ST_DEV, mcr_pkg::MCR_ST_REGADR, mcr_pkg::MCR_ST_WR: begin
          if (scl_rise && cnt_q < mcr_pkg::MCR_BITS_PER_BYTE) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == mcr_pkg::MCR_BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            st_d  = mcr_pkg::MCR_ST_IDLE;
            if (st_q == mcr_pkg::MCR_ST_DEV) begin
              if (sh_q[7:1] == {mcr_pkg::MCR_DEV_ADDR_HI, a0_q}) begin
                rw_d = sh_q[0];
                oe_d = 1'b1;
                st_d = mcr_pkg::MCR_ST_DEV_ACK;
              end
            end else if (st_q == mcr_pkg::MCR_ST_REGADR) begin
              // Only the two register addresses are acknowledged
              if (sh_q == mcr_pkg::MCR_ADR_MARGIN || sh_q == mcr_pkg::MCR_ADR_PROTCFG) begin
                ptr_d = sh_q[0]; // [R12]
                lim_d = sh_q[0] ? mcr_pkg::MCR_BURST_SINGLE : mcr_pkg::MCR_BURST_FROM_0;
                nwr_d = 2'h0;
                oe_d  = 1'b1;
                st_d  = mcr_pkg::MCR_ST_REG_ACK;
              end
            end else if (nwr_q < lim_q) begin
              // Data staged; the pointer moves on so a second byte hits 01
              if (ptr_q) begin
                stg1_d = sh_q;
                wr1_d  = 1'b1;
              end else begin
                stg0_d = sh_q;
                wr0_d  = 1'b1;
              end
              ptr_d = 1'b1; // [R13]
              nwr_d = nwr_q + 2'h1;
              oe_d  = 1'b1;
              st_d  = mcr_pkg::MCR_ST_WR_ACK;
            end
          end
        end
        mcr_pkg::MCR_ST_DEV_ACK, mcr_pkg::MCR_ST_REG_ACK, mcr_pkg::MCR_ST_WR_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (st_q != mcr_pkg::MCR_ST_DEV_ACK) begin
              st_d = mcr_pkg::MCR_ST_WR;
            end else if (rw_q) begin
              // Read starts at the pointer as the last write left it
              sh_d  = rd_cur;
              oe_d  = ~rd_cur[7];
              cnt_d = 4'h1;
              st_d  = mcr_pkg::MCR_ST_RD;
            end else begin
              st_d = mcr_pkg::MCR_ST_REGADR;
            end
          end
        end
        mcr_pkg::MCR_ST_RD: begin
          if (scl_fall) begin
            if (cnt_q < mcr_pkg::MCR_BITS_PER_BYTE) begin
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end else begin
              oe_d   = 1'b0;
              mack_d = 1'b0;
              st_d   = mcr_pkg::MCR_ST_RD_ACK;
            end
          end
        end
        mcr_pkg::MCR_ST_RD_ACK: begin
          if (scl_rise) begin
            mack_d = ~sda_s;
            if (sda_s) st_d = mcr_pkg::MCR_ST_IDLE;
          end else if (scl_fall && mack_q) begin
            // Pointer parks on the last register; further reads repeat it
            ptr_d = 1'b1;
            sh_d  = rd_last;
            oe_d  = ~rd_last[7];
            cnt_d = 4'h1;
            st_d  = mcr_pkg::MCR_ST_RD;
          end
        end
        default: begin
          st_d = mcr_pkg::MCR_ST_IDLE;
        end
      endcase
    end
    // Pin clear wins over a pending apply; it touches only this bank
    if (pin_low_s) begin
      cfg_d.margin_register            = mcr_pkg::MCR_MARGIN_RST; // [R04] [R16]
      cfg_d.protection_config_register = mcr_pkg::MCR_PROTCFG_RST; // [R04] [R05]
      wr0_d = 1'b0;
      wr1_d = 1'b0;
    end
  end

  // Power-on reset clears all but the line history, preset high; bus held off only for the strap delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_d_reg_reset: begin
        st_q    <= mcr_pkg::MCR_ST_IDLE;
        cfg_q   <= {mcr_pkg::MCR_MARGIN_RST, mcr_pkg::MCR_PROTCFG_RST}; // [R01] [R03]
        sh_q    <= 8'h00;
        stg0_q  <= 8'h00;
        stg1_q  <= 8'h00;
        cnt_q   <= 4'h0;
        nwr_q   <= 2'h0;
        lim_q   <= 2'h0;
        dly_q   <= 2'h0;
        ptr_q   <= 1'b0;
        rw_q    <= 1'b0;
        mack_q  <= 1'b0;
        wr0_q   <= 1'b0;
        wr1_q   <= 1'b0;
        oe_q    <= 1'b0;
        a0_q    <= 1'b0;
        cap_q   <= 1'b0;
        scl_p_q <= 1'b1;
        sda_p_q <= 1'b1;
      end
    end else begin
      st_q    <= st_d; // [R02]
      cfg_q   <= cfg_d;
      sh_q    <= sh_d;
      stg0_q  <= stg0_d;
      stg1_q  <= stg1_d;
      cnt_q   <= cnt_d;
      nwr_q   <= nwr_d;
      lim_q   <= lim_d;
      dly_q   <= dly_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      mack_q  <= mack_d;
      wr0_q   <= wr0_d;
      wr1_q   <= wr1_d;
      oe_q    <= oe_d;
      a0_q    <= a0_d;
      cap_q   <= cap_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Fields decode as [R06] [R07] [R08] [R09] [R10] in the package layout
  assign cfg     = cfg_q;
  assign sda_oe  = oe_q;
  assign sda_out = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end(mcr_pkg::mcr_state_t s);
    st_q == s && scl_fall && cnt_q == mcr_pkg::MCR_BITS_PER_BYTE && !start_c && !stop_c;
  endsequence

  property p_pin_clear;
    pin_low_s |=> cfg_q == '0;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin clear missed"); // [R04]

  property p_apply_margin;
    stop_c && wr0_q && !pin_low_s |=> cfg_q.margin_register == $past(stg0_q);
  endproperty
  a_apply_margin: assert property (p_apply_margin) else $error("margin not applied"); // [R15]

  property p_apply_prot;
    stop_c && wr1_q && !pin_low_s |=> cfg_q.protection_config_register == $past(stg1_q);
  endproperty
  a_apply_prot: assert property (p_apply_prot) else $error("config not applied"); // [R15]

  property p_change_cause;
    !$stable(cfg_q) |-> $past(stop_c) || $past(pin_low_s);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("config changed mid-frame"); // [R15]

  property p_bad_regadr;
    s_byte_end(mcr_pkg::MCR_ST_REGADR) ##0 sh_q[7:1] != 7'h00 |=> !oe_q && st_q == mcr_pkg::MCR_ST_IDLE;
  endproperty
  a_bad_regadr: assert property (p_bad_regadr) else $error("bad register address acked"); // [R12]

  property p_second_byte;
    s_byte_end(mcr_pkg::MCR_ST_WR) ##0 nwr_q == 2'h1 && lim_q == 2'h2 |=> oe_q && wr1_q && stg1_q == $past(sh_q);
  endproperty
  a_second_byte: assert property (p_second_byte) else $error("second byte not taken"); // [R13]

  property p_ack_release;
    (st_q == mcr_pkg::MCR_ST_WR_ACK || st_q == mcr_pkg::MCR_ST_REG_ACK) && scl_fall && !start_c && !stop_c
      |=> !oe_q ##1 st_q == mcr_pkg::MCR_ST_WR;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released"); // [R02]

  property p_read_bit;
    st_q == mcr_pkg::MCR_ST_RD && scl_fall && cnt_q < 4'h8 && !start_c && !stop_c |=> oe_q == !$past(sh_q[6]);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read bit wrong"); // [R12]

  property p_start;
    start_c |=> st_q == mcr_pkg::MCR_ST_DEV && cnt_q == 4'h0 && !oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // [R02]

endmodule

`default_nettype wire

/* mcr_bus_master.sv */
/*
  Serial bus master model for the configuration register bank.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module mcr_bus_master (
  // Clock
  input  wire logic clk,
  // Data wire level and our own drive
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Pins move just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Clock low 8 cycles, high 4; wire sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_line;
    scl = 1'b0;
    tick(4);
  endtask

  // Data falls while the clock is high
  task automatic start();
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask

  // Long tail so the slave's stop detect and apply have landed
  task automatic stop();
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(8);
  endtask

  // Most significant bit first, then the slave's answer
  task automatic byte_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Ack to continue, nack on the final byte
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask

  // Device byte, register address, then up to three data bytes
  task automatic wr_xfer(input logic [7:0] dev, input logic [7:0] adr,
                         input logic [23:0] data, input int n, output int acks);
    logic a;
    start();
    byte_wr(dev, a);
    acks = int'(a);
    if (a) begin
      byte_wr(adr, a);
      acks += int'(a);
    end
    for (int k = 0; k < n && a; k++) begin
      byte_wr(data[23 - 8 * k -: 8], a);
      acks += int'(a);
    end
    stop();
  endtask

  // Pointer must already be set by a write closed with a stop
  task automatic rd_xfer(input logic [7:0] dev, input int n, output logic [15:0] d);
    logic       a;
    logic [7:0] b;
    d = 16'h0000;
    start();
    byte_wr(dev, a);
    for (int k = 0; k < n && a; k++) begin
      byte_rd(k == n - 1, b);
      d = {d[7:0], b};
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* mcr_regs_tb_top.sv */
/*
  Self-checking bench for the margin and protection register bank.
  Assumes the master model of mcr_bus_master.sv and a pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none

module mcr_regs_tb_top;
  localparam logic [7:0] DEV_W = {mcr_pkg::MCR_DEV_ADDR_HI, 2'b10};
  localparam logic [7:0] DEV_R = {mcr_pkg::MCR_DEV_ADDR_HI, 2'b11};
  localparam logic [7:0] ADR_M = mcr_pkg::MCR_ADR_MARGIN;
  logic              clk, rst_n, pin_low, strap, scl, sda_drv, sda_line, sda_out, sda_oe;
  mcr_pkg::mcr_cfg_t cfg;
  logic [15:0]       rd;
  logic [7:0]        v;
  logic [2:0]        fseq [7] = '{3'h0, 3'h3, 3'h4, 3'h3, 3'h0, 3'h1, 3'h2};
  int                num_errors, cmp_count, acks;
  int                cycles = 0;

  // Open drain with pull-up: low when either side pulls
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  mcr_regs i_mcr_regs (
    .clk               (clk),
    .rst_n             (rst_n),
    .scl_in            (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .ss_pin_below_thr  (pin_low),
    .ss_pin_strap_high (strap),
    .cfg               (cfg)
  );

  mcr_bus_master i_mcr_bus_master (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard; the whole run needs roughly 8k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Write, then compare the number of acknowledged bytes
  task automatic wr(input logic [7:0] dev, input logic [7:0] adr,
                    input logic [23:0] d, input int n, input int exp_acks);
    i_mcr_bus_master.wr_xfer(dev, adr, d, n, acks);
    chk(acks == exp_acks, "ack count");
  endtask

  // Set the pointer with a stop, then read n bytes
  task automatic rdp(input logic [7:0] adr, input int n);
    wr(DEV_W, adr, 24'h0, 0, 2);
    i_mcr_bus_master.rd_xfer(DEV_R, n, rd);
  endtask

  // Test sequence
  initial begin
    rst_n = 1'b0;
    pin_low = 1'b0;
    strap = 1'b1;
    num_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk(cfg === 16'h0000, "cfg after power-up");
    rdp(ADR_M, 2);
    chk(rd === 16'h0000, "read after power-up");
    $display("test reset_values done");
    i_mcr_bus_master.start();
    i_mcr_bus_master.byte_wr(DEV_W, v[0]);
    i_mcr_bus_master.byte_wr(ADR_M, v[0]);
    i_mcr_bus_master.byte_wr(8'hFF, v[0]);
    chk(v[0] === 1'b1 && cfg === 16'h0000, "data applied before stop");
    i_mcr_bus_master.stop();
    chk(cfg.margin_register.offset_code === 6'h3F, "offset code");
    chk(int'(cfg.margin_register.offset_code) * mcr_pkg::MCR_OFFSET_STEP_UV == 787500,
        "offset span");
    chk(cfg.protection_config_register === 8'h00, "protcfg disturbed");
    $display("test staged_write done");
    foreach (fseq[i]) begin
      v = {2'b11, 1'b0, i[0], i[1], fseq[i]};
      wr(DEV_W, mcr_pkg::MCR_ADR_PROTCFG, {v, 16'h0}, 1, 3);
      chk(cfg.protection_config_register.freq_sel === fseq[i]
          && cfg.protection_config_register.deadtime_sel === {1'b0, i[0]}
          && cfg.protection_config_register.overvoltage_level_sel === i[1],
          "protcfg fields");
      chk(cfg.margin_register.offset_code === 6'h3F, "margin disturbed");
    end
    $display("test protcfg_codes done");
    wr(DEV_W, ADR_M, 24'h2A1500, 2, 4);
    chk(cfg === 16'h2A15, "burst write");
    wr(DEV_W, 8'h02, 24'h070000, 1, 1);
    wr(DEV_W ^ 8'h02, ADR_M, 24'h080000, 1, 0);
    chk(cfg === 16'h2A15, "refused write applied");
    rdp(ADR_M, 2);
    chk(rd === 16'h2A15, "burst read");
    rdp(mcr_pkg::MCR_ADR_PROTCFG, 1);
    chk(rd === 16'h0015, "single read");
    wr(DEV_W, ADR_M, 24'h010203, 3, 4);
    wr(DEV_W, mcr_pkg::MCR_ADR_PROTCFG, 24'h040500, 2, 3);
    chk(cfg === 16'h0104, "refused extra bytes");
    $display("test burst_refusal done");
    pin_low = 1'b1;
    @(posedge clk);
    #1;
    chk(cfg !== 16'h0000, "pin clear not synchronised");
    repeat (2) @(posedge clk);
    #1;
    chk(cfg === 16'h0000, "pin clear");
    pin_low = 1'b0;
    wr(DEV_W, ADR_M, 24'h050900, 2, 4);
    chk(cfg === 16'h0509, "write after pin clear");
    wr(DEV_W, ADR_M, 24'h0, 2, 4);
    chk(cfg === 16'h0000, "zero write");
    wr(DEV_W, ADR_M, 24'h330000, 1, 3);
    chk(cfg === 16'h3300, "write before supply drop");
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk(cfg === 16'h0000 && sda_oe === 1'b0, "supply drop clear");
    rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    rdp(ADR_M, 1);
    chk(rd === 16'h0000, "read after supply drop");
    $display("test clears done");
    end_sim();
  end
endmodule
`default_nettype wire
